// ==== rtl/wake_pkg.sv ====
// constants, types and register layout for the wakeup control/status bank
package wake_pkg;
   localparam logic [11:0] WAKE_CTL_STS_OFFSET  = 12'h140;
   localparam logic [11:0] RESUME_CTL_OFFSET    = 12'h150;
   localparam int          FILTER_WAKE_EN_BIT   = 14;
   localparam int          LPI_TX_FLAG_BIT      = 13;
   localparam int          LPI_TX_EN_BIT        = 12;
   localparam int          LPI_RX_FLAG_BIT      = 11;
   localparam int          LPI_RX_EN_BIT        = 10;
   localparam int          FILTER_FLAG_BIT      = 9;
   localparam int          STORE_WAKE_BIT       = 8;
   localparam int          OWN_ADDR_FLAG_BIT    = 7;
   localparam int          PATTERN_FLAG_BIT     = 6;
   localparam int          CLR_ENABLES_BIT      = 0;
   localparam int          CLR_FLAGS_BIT        = 1;
   localparam logic [31:0] ENABLE_MASK          = 32'h0000_5500;
   localparam logic [31:0] FLAG_MASK            = 32'h0000_2AC0;
   localparam logic [31:0] RESUME_CLR_EN_MASK   = 32'h0000_5400; // wake enables only, store wake kept
   localparam logic [31:0] RESUME_CTL_MASK      = 32'h0000_0003;
   localparam logic [31:0] REG_RESET            = 32'h0000_0000;
   localparam logic [1:0]  RESUME_CTL_RESET     = 2'h0;

   // life cycle of one deep suspend; gray codes along the usual path
   typedef enum logic [1:0] {
      RUN        = 2'b00,
      SLEEP      = 2'b01,
      WOKE_FRAME = 2'b11,
      WOKE_OTHER = 2'b10
   } suspend_e;

   // per-frame report from the receive MAC and receive_filter_engine
   typedef struct packed {
      logic frame_done;
      logic frame_ok;
      logic filter_pass;
      logic own_address;
      logic pattern_match;
   } frame_event_s;

   // low power idle exits reported by the EEE logic
   typedef struct packed {
      logic tx_exit_delay;
      logic rx_exit_wake;
   } lpi_event_s;

   // register port from software
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_s;
endpackage

// ==== rtl/wakeup_control_status.sv ====
// wakeup control/status register bank with wake event and frame-store steering
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// R1 - software keeps all enables clear in normal operation, else receive misbehaves
// R2 - filter wake enable lets a good filtered frame raise a wakeup
// R3 - resume completion clears enables when resume_clears_enables is set; the code clears only the three wake enables and keeps store wake
// R4 - resume completion clears flags when resume_clears_flags is set
// R5 - tx lpi exit after request delay sets lpi_tx_exit_flag
// R6 - lpi_tx_exit_flag never sets while its enable is clear
// R7 - both lpi flags held zero while energy_efficient_enable is low
// R8 - tx lpi exit is a wake event when its enable is set
// R9 - rx lpi exit on wake signalling sets rx flag, only if enabled
// R10 - rx wake signalling is a wake event when its enable is set
// R11 - good frame passing filter engine sets filter_wake_frame_flag
// R12 - store wake set: store waking frame and later good filtered frames
// R13 - store wake clear: store only later good filtered frames
// R14 - wake not caused by a frame: store all later frames
// R15 - store wake bit matters only in deep_suspend_state
// R16 - frame matching own address sets own_address_frame_flag
// R17 - frame matching wakeup pattern filter sets pattern_wake_frame_flag
// R18 - flags sticky until written one; reserved bits read zero
// R19 - all enables and flags reset to zero
module wakeup_control_status (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire wake_pkg::reg_req_s    reg_req,
   output logic [31:0]                reg_rdata,
   input  wire wake_pkg::frame_event_s frame_evt,
   input  wire wake_pkg::lpi_event_s  lpi_evt,
   input  wire logic                  energy_efficient_enable,
   input  wire logic                  deep_suspend_state,
   input  wire logic                  resume_done,
   output logic                       wake_request,
   output logic                       store_frame
);

   logic [31:0]        bank_reg;
   logic [31:0]        bank_next;
   logic [1:0]         resume_ctl_reg;
   logic [31:0]        rdata_reg;
   logic               wake_request_reg;
   logic               store_frame_reg;
   wake_pkg::suspend_e state_reg;
   wake_pkg::suspend_e state_next;
   logic               good_frame;
   logic               frame_wake;
   logic               other_wake;
   logic               wr_bank;
   logic               wr_resume;
   logic               store_now;

   // every check below samples on mclk and rests while reset is low
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // a received frame with no error that the filter engine accepts
   function automatic logic passes(input wake_pkg::frame_event_s f);
      passes = f.frame_done & f.frame_ok & f.filter_pass;
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   assign good_frame = passes(frame_evt);
   assign wr_bank    = reg_req.wr & hit(reg_req.addr, wake_pkg::WAKE_CTL_STS_OFFSET);
   assign wr_resume  = reg_req.wr & hit(reg_req.addr, wake_pkg::RESUME_CTL_OFFSET);

   // wake causes, each gated by its own enable
   assign frame_wake = bank_reg[wake_pkg::FILTER_WAKE_EN_BIT] & good_frame; // R2
   assign other_wake = (bank_reg[wake_pkg::LPI_TX_EN_BIT] & lpi_evt.tx_exit_delay)  // R8
                     | (bank_reg[wake_pkg::LPI_RX_EN_BIT] & lpi_evt.rx_exit_wake);  // R10

   // next value of the bank: write, resume clear, then hardware sets on top
   always_comb begin
      bank_next = bank_reg;
      if (wr_bank) begin
         bank_next = (bank_reg & ~wake_pkg::ENABLE_MASK) | (reg_req.wdata & wake_pkg::ENABLE_MASK);
         bank_next = bank_next & ~(reg_req.wdata & wake_pkg::FLAG_MASK); // R18
      end else if (resume_done && resume_ctl_reg[wake_pkg::CLR_ENABLES_BIT]) begin
         // store wake is a storage setting, not a wake enable, so resume leaves it alone
         bank_next = bank_next & ~wake_pkg::RESUME_CLR_EN_MASK; // R3
      end
      if (resume_done && resume_ctl_reg[wake_pkg::CLR_FLAGS_BIT]) begin
         bank_next = bank_next & ~wake_pkg::FLAG_MASK; // R4
      end
      // sets win over write and resume clears in the same cycle
      if (lpi_evt.tx_exit_delay && bank_reg[wake_pkg::LPI_TX_EN_BIT]) begin
         bank_next[wake_pkg::LPI_TX_FLAG_BIT] = 1'b1; // R5 R6
      end
      if (lpi_evt.rx_exit_wake && bank_reg[wake_pkg::LPI_RX_EN_BIT]) begin
         bank_next[wake_pkg::LPI_RX_FLAG_BIT] = 1'b1; // R9
      end
      if (good_frame) begin
         bank_next[wake_pkg::FILTER_FLAG_BIT] = 1'b1; // R11
      end
      if (frame_evt.frame_done && frame_evt.frame_ok && frame_evt.own_address) begin
         bank_next[wake_pkg::OWN_ADDR_FLAG_BIT] = 1'b1; // R16
      end
      if (frame_evt.frame_done && frame_evt.frame_ok && frame_evt.pattern_match) begin
         bank_next[wake_pkg::PATTERN_FLAG_BIT] = 1'b1; // R17
      end
      // lpi flags are forced low with EEE off, beating even a set
      if (!energy_efficient_enable) begin
         bank_next[wake_pkg::LPI_TX_FLAG_BIT] = 1'b0; // R7
         bank_next[wake_pkg::LPI_RX_FLAG_BIT] = 1'b0; // R7
      end
      bank_next = bank_next & (wake_pkg::ENABLE_MASK | wake_pkg::FLAG_MASK); // R18
   end

   // wake control/status bank
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bank_reg <= wake_pkg::REG_RESET; // R19
      end else begin
         bank_reg <= bank_next;
      end
   end

   // resume behaviour control bits
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         resume_ctl_reg <= wake_pkg::RESUME_CTL_RESET;
      end else if (wr_resume) begin
         resume_ctl_reg <= reg_req.wdata[1:0];
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_req.rd && hit(reg_req.addr, wake_pkg::WAKE_CTL_STS_OFFSET)) begin
         rdata_reg <= bank_reg; // R18
      end else if (reg_req.rd && hit(reg_req.addr, wake_pkg::RESUME_CTL_OFFSET)) begin
         rdata_reg <= {30'h0000_0000, resume_ctl_reg};
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // suspend tracking; only deep suspend changes frame storage
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         wake_pkg::RUN: begin
            if (deep_suspend_state) begin
               state_next = wake_pkg::SLEEP;
            end
         end
         wake_pkg::SLEEP: begin
            if (!deep_suspend_state) begin
               state_next = wake_pkg::RUN;
            end else if (frame_wake) begin
               state_next = wake_pkg::WOKE_FRAME;
            end else if (other_wake) begin
               state_next = wake_pkg::WOKE_OTHER;
            end
         end
         wake_pkg::WOKE_FRAME, wake_pkg::WOKE_OTHER: begin
            if (!deep_suspend_state) begin
               state_next = wake_pkg::RUN;
            end
         end
      endcase
   end

   // suspend state register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= wake_pkg::RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // store decision per finished frame for the fifo_controller
   always_comb begin
      store_now = 1'b0;
      unique case (state_reg)
         wake_pkg::RUN:        store_now = good_frame; // R15
         wake_pkg::SLEEP:      store_now = frame_wake & bank_reg[wake_pkg::STORE_WAKE_BIT]; // R12 R13 R15
         wake_pkg::WOKE_FRAME: store_now = good_frame; // R12 R13
         wake_pkg::WOKE_OTHER: store_now = frame_evt.frame_done; // R14
      endcase
   end

   // registered outputs; a wake pulse is raised in any power state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wake_request_reg <= 1'b0;
         store_frame_reg  <= 1'b0;
      end else begin
         wake_request_reg <= frame_wake | other_wake; // R2 R8 R10
         store_frame_reg  <= store_now;
      end
   end

   assign reg_rdata    = rdata_reg;
   assign wake_request = wake_request_reg;
   assign store_frame  = store_frame_reg;

   chk_lpi_held_low: assert property (!energy_efficient_enable |=> // R7
      !bank_reg[wake_pkg::LPI_TX_FLAG_BIT] && !bank_reg[wake_pkg::LPI_RX_FLAG_BIT])
      else $error("lpi flag set with EEE off");

   chk_tx_flag_gated: assert property ($rose(bank_reg[wake_pkg::LPI_TX_FLAG_BIT]) |-> // R6
      $past(bank_reg[wake_pkg::LPI_TX_EN_BIT]) && $past(lpi_evt.tx_exit_delay))
      else $error("tx lpi flag rose without enable and exit");

   chk_tx_flag_sets: assert property (energy_efficient_enable && lpi_evt.tx_exit_delay // R5
      && bank_reg[wake_pkg::LPI_TX_EN_BIT] ##1 energy_efficient_enable |-> bank_reg[wake_pkg::LPI_TX_FLAG_BIT])
      else $error("tx lpi flag missed");

   chk_rx_flag_gated: assert property (!bank_reg[wake_pkg::LPI_RX_EN_BIT] // R9
      && !bank_reg[wake_pkg::LPI_RX_FLAG_BIT] |=> !bank_reg[wake_pkg::LPI_RX_FLAG_BIT])
      else $error("rx lpi flag set while disabled");

   chk_filter_flag_set: assert property (good_frame |=> bank_reg[wake_pkg::FILTER_FLAG_BIT]) // R11
      else $error("filter frame flag missed");

   chk_flag_sticky: assert property (bank_reg[wake_pkg::OWN_ADDR_FLAG_BIT] && !wr_bank // R18
      && !resume_done |=> bank_reg[wake_pkg::OWN_ADDR_FLAG_BIT])
      else $error("own address flag dropped");

   chk_resume_enables: assert property (resume_done && resume_ctl_reg[wake_pkg::CLR_ENABLES_BIT] // R3
      && !wr_bank |=> (bank_reg & wake_pkg::RESUME_CLR_EN_MASK) == 32'h0000_0000)
      else $error("enables survived resume");

   chk_resume_flags: assert property (resume_done && resume_ctl_reg[wake_pkg::CLR_FLAGS_BIT] // R4
      && !frame_evt.frame_done && !lpi_evt.tx_exit_delay && !lpi_evt.rx_exit_wake
      |=> (bank_reg & wake_pkg::FLAG_MASK) == 32'h0000_0000)
      else $error("flags survived resume");

   chk_wake_pulse: assert property (frame_wake ##1 1'b1 |-> wake_request) // R2
      else $error("wake request missed");

   chk_sleep_store: assert property (state_reg == wake_pkg::SLEEP // R13
      && !bank_reg[wake_pkg::STORE_WAKE_BIT] |=> !store_frame)
      else $error("frame stored while asleep");

   chk_other_store: assert property (state_reg == wake_pkg::WOKE_OTHER // R14
      && frame_evt.frame_done |=> store_frame)
      else $error("frame dropped after non-frame wake");

   chk_read_reserved: assert property (reg_req.rd && hit(reg_req.addr, wake_pkg::WAKE_CTL_STS_OFFSET) // R18
      |=> (reg_rdata & ~(wake_pkg::ENABLE_MASK | wake_pkg::FLAG_MASK)) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

   // lpi flags and wake requests
   chk_rx_flag_sets: assert property (energy_efficient_enable && lpi_evt.rx_exit_wake // R9
      && bank_reg[wake_pkg::LPI_RX_EN_BIT] |=> bank_reg[wake_pkg::LPI_RX_FLAG_BIT])
      else $error("rx lpi flag missed");

   chk_tx_flag_blocked: assert property (!bank_reg[wake_pkg::LPI_TX_EN_BIT] // R6
      && !bank_reg[wake_pkg::LPI_TX_FLAG_BIT] |=> !bank_reg[wake_pkg::LPI_TX_FLAG_BIT])
      else $error("tx lpi flag set while disabled");

   chk_tx_wake_pulse: assert property (bank_reg[wake_pkg::LPI_TX_EN_BIT] && lpi_evt.tx_exit_delay // R8
      |=> wake_request)
      else $error("tx lpi exit raised no wake");

   chk_rx_wake_pulse: assert property (bank_reg[wake_pkg::LPI_RX_EN_BIT] && lpi_evt.rx_exit_wake // R10
      |=> wake_request)
      else $error("rx wake signalling raised no wake");

   chk_wake_needs_cause: assert property (!good_frame && !lpi_evt.tx_exit_delay // R2
      && !lpi_evt.rx_exit_wake |=> !wake_request)
      else $error("wake request without a cause");

   chk_filter_wake_gated: assert property (!bank_reg[wake_pkg::FILTER_WAKE_EN_BIT] // R2
      && !lpi_evt.tx_exit_delay && !lpi_evt.rx_exit_wake |=> !wake_request)
      else $error("frame wake while filter wake disabled");

   // frame flags, software writes and resume clears
   chk_own_flag_set: assert property (frame_evt.frame_done && frame_evt.frame_ok // R16
      && frame_evt.own_address |=> bank_reg[wake_pkg::OWN_ADDR_FLAG_BIT])
      else $error("own address flag missed");

   chk_pattern_flag_set: assert property (frame_evt.frame_done && frame_evt.frame_ok // R17
      && frame_evt.pattern_match |=> bank_reg[wake_pkg::PATTERN_FLAG_BIT])
      else $error("pattern flag missed");

   chk_flag_write_clear: assert property (wr_bank && reg_req.wdata[wake_pkg::FILTER_FLAG_BIT] // R18
      && !good_frame |=> !bank_reg[wake_pkg::FILTER_FLAG_BIT])
      else $error("filter flag survived a one written");

   chk_enable_write: assert property (wr_bank |=> (bank_reg & wake_pkg::ENABLE_MASK) // R18
      == ($past(reg_req.wdata) & wake_pkg::ENABLE_MASK))
      else $error("enable write lost");

   chk_store_survives: assert property (resume_done && !wr_bank // R3
      |=> bank_reg[wake_pkg::STORE_WAKE_BIT] == $past(bank_reg[wake_pkg::STORE_WAKE_BIT]))
      else $error("store wake changed by resume");

   chk_filter_sticky: assert property (bank_reg[wake_pkg::FILTER_FLAG_BIT] && !wr_bank // R18
      && !resume_done |=> bank_reg[wake_pkg::FILTER_FLAG_BIT])
      else $error("filter flag dropped");

   // frame storage across deep suspend
   chk_run_store: assert property (state_reg == wake_pkg::RUN && good_frame // R15
      |=> store_frame)
      else $error("good frame not stored while running");

   chk_run_drop: assert property (state_reg == wake_pkg::RUN && !good_frame // R15
      |=> !store_frame)
      else $error("bad frame stored while running");

   chk_sleep_entry: assert property (state_reg == wake_pkg::RUN && deep_suspend_state // R15
      |=> state_reg == wake_pkg::SLEEP)
      else $error("deep suspend not entered");

   chk_wake_frame_store: assert property (state_reg == wake_pkg::SLEEP && frame_wake // R12
      && bank_reg[wake_pkg::STORE_WAKE_BIT] |=> store_frame)
      else $error("waking frame not stored");

   chk_woke_drop_bad: assert property (state_reg == wake_pkg::WOKE_FRAME && !good_frame // R12
      |=> !store_frame)
      else $error("bad frame stored after frame wake");

   chk_woke_keep_good: assert property (state_reg == wake_pkg::WOKE_FRAME && good_frame // R13
      |=> store_frame)
      else $error("good frame dropped after frame wake");

   chk_leave_suspend: assert property (!deep_suspend_state // R15
      |=> state_reg == wake_pkg::RUN)
      else $error("suspend tracking stuck");

   chk_store_needs_done: assert property (!frame_evt.frame_done // R14
      |=> !store_frame)
      else $error("store without a finished frame");

   // read port
   chk_read_idle: assert property (!reg_req.rd // R18
      |=> reg_rdata == 32'h0000_0000)
      else $error("read data without a read");

   chk_read_bank: assert property (reg_req.rd && hit(reg_req.addr, wake_pkg::WAKE_CTL_STS_OFFSET) // R18
      |=> reg_rdata == $past(bank_reg))
      else $error("bank read data wrong");

endmodule

// ==== test/wakeup_control_status_tb_top.sv ====
// self-checking bench for the wakeup control/status bank
`timescale 1ns/10ps

module wakeup_control_status_tb_top;
   logic                  mclk;
   logic                  reset_n;
   wake_pkg::reg_req_s    reg_req;
   logic [31:0]           reg_rdata;
   wake_pkg::frame_event_s frame_evt;
   wake_pkg::lpi_event_s  lpi_evt;
   logic                  eee_en;
   logic                  deep;
   logic                  resume_done;
   logic                  wake_request;
   logic                  store_frame;
   int                    fails;
   int                    checked;

   wakeup_control_status dut (
      .mclk                    (mclk),
      .reset_n                 (reset_n),
      .reg_req                 (reg_req),
      .reg_rdata               (reg_rdata),
      .frame_evt               (frame_evt),
      .lpi_evt                 (lpi_evt),
      .energy_efficient_enable (eee_en),
      .deep_suspend_state      (deep),
      .resume_done             (resume_done),
      .wake_request            (wake_request),
      .store_frame             (store_frame)
   );

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one-cycle write strobe; strobe drops at the next edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      reg_req.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so look there
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      reg_req.rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   // one-cycle event pulses, then the registered outputs one cycle later
   task automatic ev(input logic [4:0] f, input logic [1:0] l, input logic r, input logic ew, input logic es);
      @(posedge mclk);
      frame_evt   <= wake_pkg::frame_event_s'(f);
      lpi_evt     <= wake_pkg::lpi_event_s'(l);
      resume_done <= r;
      @(posedge mclk);
      frame_evt   <= '0;
      lpi_evt     <= '0;
      resume_done <= 1'b0;
      #1 check({30'h0, wake_request, store_frame}, {30'h0, ew, es});
   endtask

   // program the bank, then leave and re-enter deep suspend
   task automatic sleep(input logic [31:0] bank);
      wr(wake_pkg::WAKE_CTL_STS_OFFSET, bank);
      @(posedge mclk);
      deep <= 1'b0;
      @(posedge mclk);
      deep <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask

   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      close_out();
   end

   initial begin
      fails = 0;
      checked = 0;
      reset_n = 1'b0;
      reg_req = '0;
      frame_evt = '0;
      lpi_evt = '0;
      eee_en = 1'b0;
      deep = 1'b0;
      resume_done = 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(12'h140, 32'h0000_0000);
      rd(12'h150, 32'h0000_0000);
      rd(12'h144, 32'h0000_0000);
      wr(12'h140, 32'hFFFF_FFFF);
      rd(12'h140, 32'h0000_5500);
      // errored frame must not raise anything, good frame raises all three flags
      ev(5'b10111, 2'b00, 1'b0, 1'b0, 1'b0);
      rd(12'h140, 32'h0000_5500);
      ev(5'b11111, 2'b00, 1'b0, 1'b1, 1'b1);
      rd(12'h140, 32'h0000_57C0);
      wr(12'h140, 32'h0000_5580);
      rd(12'h140, 32'h0000_5740);
      wr(12'h140, 32'h0000_5740);
      rd(12'h140, 32'h0000_5500);
      // lpi exits wake even with eee off, but flags stay low
      ev(5'b00000, 2'b10, 1'b0, 1'b1, 1'b0);
      ev(5'b00000, 2'b01, 1'b0, 1'b1, 1'b0);
      rd(12'h140, 32'h0000_5500);
      eee_en <= 1'b1;
      ev(5'b00000, 2'b10, 1'b0, 1'b1, 1'b0);
      ev(5'b00000, 2'b01, 1'b0, 1'b1, 1'b0);
      rd(12'h140, 32'h0000_7D00);
      eee_en <= 1'b0;
      rd(12'h140, 32'h0000_5500);
      eee_en <= 1'b1;
      wr(12'h140, 32'h0000_2800);
      ev(5'b00000, 2'b10, 1'b0, 1'b0, 1'b0);
      ev(5'b00000, 2'b01, 1'b0, 1'b0, 1'b0);
      rd(12'h140, 32'h0000_0000);
      // resume clears flags only, then enables only
      wr(12'h150, 32'hFFFF_FFFE);
      rd(12'h150, 32'h0000_0002);
      wr(12'h140, 32'h0000_5500);
      ev(5'b00000, 2'b10, 1'b0, 1'b1, 1'b0);
      ev(5'b00000, 2'b00, 1'b1, 1'b0, 1'b0);
      rd(12'h140, 32'h0000_5500);
      wr(12'h150, 32'h0000_0001);
      ev(5'b00000, 2'b10, 1'b0, 1'b1, 1'b0);
      ev(5'b00000, 2'b00, 1'b1, 1'b0, 1'b0);
      rd(12'h140, 32'h0000_2100);
      wr(12'h148, 32'hFFFF_FFFF);
      rd(12'h140, 32'h0000_2100);
      wr(12'h140, 32'h0000_2000);
      // deep suspend with the waking frame kept
      sleep(32'h0000_4100);
      ev(5'b11100, 2'b00, 1'b0, 1'b1, 1'b1);
      ev(5'b11100, 2'b00, 1'b0, 1'b1, 1'b1);
      ev(5'b10100, 2'b00, 1'b0, 1'b0, 1'b0);
      // waking frame dropped, later good frames kept
      sleep(32'h0000_4000);
      ev(5'b11100, 2'b00, 1'b0, 1'b1, 1'b0);
      ev(5'b11100, 2'b00, 1'b0, 1'b1, 1'b1);
      // non-frame wake keeps every later frame, even errored ones
      sleep(32'h0000_0400);
      ev(5'b11100, 2'b00, 1'b0, 1'b0, 1'b0);
      ev(5'b00000, 2'b01, 1'b0, 1'b1, 1'b0);
      ev(5'b10000, 2'b00, 1'b0, 1'b0, 1'b1);
      // outside deep suspend the store bit has no say
      deep <= 1'b0;
      wr(12'h140, 32'h0000_4800);
      ev(5'b11100, 2'b00, 1'b0, 1'b1, 1'b1);
      // back to normal operation: every enable cleared, flags acknowledged
      wr(12'h140, 32'h0000_2AC0);
      rd(12'h140, 32'h0000_0000);
      close_out();
   end
endmodule
